// *** rtl/lbrt_core.sv ***
// lpddr2 column burst logic: command decode, burst slots, data, counters
`timescale 1ns/1ps
module lbrt_core
(
	// core clock domain
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire lbrt_pkg::lbrt_cfg_type cfg_i,
	output logic [lbrt_pkg::CNT_W-1:0] rd_count_o,
	output logic [lbrt_pkg::CNT_W-1:0] wr_count_o,
	output logic [lbrt_pkg::CNT_W-1:0] stop_count_o,
	output logic auto_close_o,
	// link clock domain: command bus
	input wire logic link_clk_i,
	input wire logic cs_n_i,
	input wire logic [9:0] ca_rise_i,
	input wire logic [9:0] ca_fall_i,
	// link clock domain: data
	input wire logic [lbrt_pkg::PAIR_W-1:0] wdata_i,
	input wire logic wdata_valid_i,
	output logic [lbrt_pkg::PAIR_W-1:0] rdata_o,
	output logic rdq_oe_o,
	output logic rdqs_oe_o
);
	// ------------------------------------------------------------
	// link reset and configuration crossing
	// ------------------------------------------------------------
	logic [1:0] lrst_sync_reg;
	lbrt_pkg::lbrt_cfg_type cfg_s1_reg;
	lbrt_pkg::lbrt_cfg_type cfg_reg;
	wire lrst_n = lrst_sync_reg[1];

	always_ff @(posedge link_clk_i)
	begin
		lrst_sync_reg <= {lrst_sync_reg[0], rstn_i};
	end

	// configuration must be static while commands run
	always_ff @(posedge link_clk_i)
	begin
		cfg_s1_reg <= cfg_i;
		cfg_reg <= cfg_s1_reg;
	end

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	wire cmd_col = !cs_n_i && ca_rise_i[lbrt_pkg::CA_BIT0]
		&& !ca_rise_i[lbrt_pkg::CA_BIT1];
	wire cmd_wr = cmd_col && !ca_rise_i[lbrt_pkg::CA_BIT2];
	wire cmd_rd = cmd_col && ca_rise_i[lbrt_pkg::CA_BIT2];
	wire cmd_stop = !cs_n_i && ca_rise_i[lbrt_pkg::CA_BIT0]
		&& ca_rise_i[lbrt_pkg::CA_BIT1] && !ca_rise_i[lbrt_pkg::CA_BIT2]
		&& !ca_rise_i[lbrt_pkg::CA_BIT3];
	wire cmd_any = cmd_wr || cmd_rd;
	// start column, beat pair index is column bits 5:1
	wire [10:0] start_col = {ca_fall_i[lbrt_pkg::COL_FALL_HI:
		lbrt_pkg::COL_FALL_LO], ca_rise_i[lbrt_pkg::COL_RISE_HI:
		lbrt_pkg::COL_RISE_LO]};
	wire [lbrt_pkg::ADDR_W-1:0] start_pair =
		start_col[lbrt_pkg::PAIR_HI:lbrt_pkg::PAIR_LO];
	wire auto_close = ca_fall_i[lbrt_pkg::AP_BIT];

	wire [3:0] pairs =
		(cfg_reg.burst == lbrt_pkg::BURST_16) ? lbrt_pkg::PAIRS_16 :
		(cfg_reg.burst == lbrt_pkg::BURST_8) ? lbrt_pkg::PAIRS_8 :
		lbrt_pkg::PAIRS_4;

	// ------------------------------------------------------------
	// burst slot generator
	// ------------------------------------------------------------
	logic [3:0] rem_reg;
	logic [3:0] rem_next;
	logic cur_rd_reg;
	logic [lbrt_pkg::ADDR_W-1:0] addr_reg;
	logic [lbrt_pkg::ADDR_W-1:0] addr_next;
	lbrt_pkg::lbrt_slot_type slot_now;

	// a new command restarts the count, so an interrupted burst ends
	// after one pair for each clock between the two commands
	always_comb
	begin
		slot_now = '0;
		rem_next = rem_reg;
		addr_next = addr_reg;
		if (cmd_any)
		begin
			slot_now.valid = 1'b1;
			slot_now.rd = cmd_rd;
			slot_now.addr = start_pair;
			rem_next = pairs - lbrt_pkg::ONE_4;
			addr_next = start_pair + lbrt_pkg::ONE_A;
		end
		else if (cmd_stop)
		begin
			rem_next = '0;
		end
		else if (rem_reg != '0)
		begin
			slot_now.valid = 1'b1;
			slot_now.rd = cur_rd_reg;
			slot_now.addr = addr_reg;
			rem_next = rem_reg - lbrt_pkg::ONE_4;
			addr_next = addr_reg + lbrt_pkg::ONE_A;
		end
	end

	always_ff @(posedge link_clk_i)
	begin
		if (!lrst_n)
		begin
			rem_reg <= '0;
			cur_rd_reg <= 1'b0;
			addr_reg <= '0;
		end
		else
		begin
			rem_reg <= rem_next;
			addr_reg <= addr_next;
			if (cmd_any)
				cur_rd_reg <= cmd_rd;
		end
	end

	// ------------------------------------------------------------
	// latency pipeline
	// ------------------------------------------------------------
	lbrt_pkg::lbrt_slot_type pipe_reg [lbrt_pkg::PIPE_DEPTH];

	always_ff @(posedge link_clk_i)
	begin
		if (!lrst_n)
			pipe_reg <= '{default: '0};
		else
			pipe_reg <= {slot_now, pipe_reg[0:lbrt_pkg::PIPE_DEPTH-2]};
	end

	wire [3:0] rd_tap = cfg_reg.rd_delay - lbrt_pkg::ONE_4;
	wire [3:0] wr_tap = cfg_reg.wr_delay - lbrt_pkg::ONE_4;
	lbrt_pkg::lbrt_slot_type rd_slot;
	lbrt_pkg::lbrt_slot_type wr_slot;
	assign rd_slot = pipe_reg[rd_tap];
	assign wr_slot = pipe_reg[wr_tap];
	wire rd_beat = rd_slot.valid && rd_slot.rd;
	wire wr_beat = wr_slot.valid && !wr_slot.rd;

	// ------------------------------------------------------------
	// data array, write capture and read drive
	// ------------------------------------------------------------
	logic [lbrt_pkg::PAIR_W-1:0] mem [lbrt_pkg::MEM_WORDS];

	always_ff @(posedge link_clk_i)
	begin
		if (wr_beat && wdata_valid_i)
			mem[wr_slot.addr] <= wdata_i;
	end

	// bus released in the clock after the last live slot
	always_ff @(posedge link_clk_i)
	begin
		if (!lrst_n)
		begin
			rdata_o <= '0;
			rdq_oe_o <= 1'b0;
			rdqs_oe_o <= 1'b0;
		end
		else
		begin
			rdata_o <= rd_beat ? mem[rd_slot.addr] : '0;
			rdq_oe_o <= rd_beat;
			rdqs_oe_o <= rd_beat;
		end
	end

	// ------------------------------------------------------------
	// command counters, gray coded toward the core clock
	// ------------------------------------------------------------
	// commands come faster than the core clock, so counts are kept
	// here; gray code moves one bit per step, so a sample taken
	// mid-change reads the old or the new count, never a mix
	wire [lbrt_pkg::EV_N-1:0] ev_hit = {cmd_stop, cmd_wr, cmd_rd};
	logic [lbrt_pkg::EV_N-1:0][lbrt_pkg::CNT_W-1:0] lcnt_reg;
	logic [lbrt_pkg::EV_N-1:0][lbrt_pkg::CNT_W-1:0] lcnt_next;
	logic [lbrt_pkg::EV_N-1:0][lbrt_pkg::CNT_W-1:0] lgray_reg;
	logic [lbrt_pkg::EV_N-1:0][lbrt_pkg::CNT_W-1:0] lgray_next;
	logic ap_reg;

	always_comb
	begin
		for (int e = 0; e < lbrt_pkg::EV_N; e++)
		begin
			lcnt_next[e] = lcnt_reg[e] + (ev_hit[e] ? lbrt_pkg::ONE_C : '0);
			lgray_next[e] = lcnt_next[e] ^ (lcnt_next[e] >> 1);
		end
	end

	always_ff @(posedge link_clk_i)
	begin
		if (!lrst_n)
		begin
			lcnt_reg <= '0;
			lgray_reg <= '0;
			ap_reg <= 1'b0;
		end
		else
		begin
			lcnt_reg <= lcnt_next;
			lgray_reg <= lgray_next;
			if (cmd_any)
				ap_reg <= auto_close;
		end
	end

	// ------------------------------------------------------------
	// core clock side: synchronisers and counters
	// ------------------------------------------------------------
	logic [lbrt_pkg::EV_N-1:0][lbrt_pkg::CNT_W-1:0] gray_s1_reg;
	logic [lbrt_pkg::EV_N-1:0][lbrt_pkg::CNT_W-1:0] gray_s2_reg;
	logic [lbrt_pkg::EV_N-1:0][lbrt_pkg::CNT_W-1:0] core_cnt;
	logic [1:0] ap_sync_reg;

	always_ff @(posedge core_clk_i)
	begin
		gray_s1_reg <= lgray_reg;
		gray_s2_reg <= gray_s1_reg;
		ap_sync_reg <= {ap_sync_reg[0], ap_reg};
	end

	// gray to binary: each bit is the parity of itself and the bits above it
	always_comb
	begin
		for (int e = 0; e < lbrt_pkg::EV_N; e++)
		begin
			for (int i = 0; i < lbrt_pkg::CNT_W; i++)
			begin
				core_cnt[e][i] = ^(gray_s2_reg[e] >> i);
			end
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
		begin
			rd_count_o <= '0;
			wr_count_o <= '0;
			stop_count_o <= '0;
			auto_close_o <= 1'b0;
		end
		else
		begin
			rd_count_o <= core_cnt[lbrt_pkg::EV_RD];
			wr_count_o <= core_cnt[lbrt_pkg::EV_WR];
			stop_count_o <= core_cnt[lbrt_pkg::EV_STOP];
			auto_close_o <= ap_sync_reg[1];
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_stop_seen;
		cmd_stop && !cmd_any;
	endsequence

	property p_wr_decode;
		@(posedge link_clk_i) disable iff (!lrst_n)
		cmd_wr |-> slot_now.valid && !slot_now.rd;
	endproperty
	a_wr_decode: assert property (p_wr_decode)
		else $error("write command did not start a write slot");

	property p_rd_decode;
		@(posedge link_clk_i) disable iff (!lrst_n)
		cmd_rd |-> slot_now.valid && slot_now.rd;
	endproperty
	a_rd_decode: assert property (p_rd_decode)
		else $error("read command did not start a read slot");

	property p_col;
		@(posedge link_clk_i) disable iff (!lrst_n)
		cmd_any |=> addr_reg == $past(start_pair) + lbrt_pkg::ONE_A;
	endproperty
	a_col: assert property (p_col)
		else $error("start column not taken from ca bus");

	property p_len;
		@(posedge link_clk_i) disable iff (!lrst_n)
		cmd_any |=> rem_reg == $past(pairs) - lbrt_pkg::ONE_4;
	endproperty
	a_len: assert property (p_len)
		else $error("burst length count wrong");

	property p_interrupt;
		@(posedge link_clk_i) disable iff (!lrst_n)
		(cmd_rd && rem_reg != '0) |=> cur_rd_reg && rem_reg == $past(pairs)
			- lbrt_pkg::ONE_4;
	endproperty
	a_interrupt: assert property (p_interrupt)
		else $error("interrupting read did not restart burst");

	property p_stop;
		@(posedge link_clk_i) disable iff (!lrst_n)
		s_stop_seen |-> !slot_now.valid ##1 rem_reg == '0;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop did not end the burst");

	property p_stop_wr;
		@(posedge link_clk_i) disable iff (!lrst_n)
		(s_stop_seen ##1 !cmd_any) |-> !slot_now.valid;
	endproperty
	a_stop_wr: assert property (p_stop_wr)
		else $error("slot issued after stop");

	property p_release;
		@(posedge link_clk_i) disable iff (!lrst_n)
		!rd_beat |=> !rdq_oe_o && !rdqs_oe_o;
	endproperty
	a_release: assert property (p_release)
		else $error("data bus driven with no read beat");

	property p_drive;
		@(posedge link_clk_i) disable iff (!lrst_n)
		rd_beat |=> rdq_oe_o && rdqs_oe_o;
	endproperty
	a_drive: assert property (p_drive)
		else $error("read beat not driven");

	property p_ap;
		@(posedge link_clk_i) disable iff (!lrst_n)
		cmd_any |=> ap_reg == $past(auto_close);
	endproperty
	a_ap: assert property (p_ap)
		else $error("auto close flag not captured");
endmodule : lbrt_core

// *** inc/lbrt_pkg.sv ***
// constants and types for the lpddr2 column burst block
package lbrt_pkg;
	// command field positions on the ca bus
	localparam int CA_BIT0 = 0;
	localparam int CA_BIT1 = 1;
	localparam int CA_BIT2 = 2;
	localparam int CA_BIT3 = 3;
	localparam int COL_RISE_LO = 5;
	localparam int COL_RISE_HI = 6;
	localparam int COL_FALL_LO = 1;
	localparam int COL_FALL_HI = 9;
	localparam int AP_BIT = 0;
	// beat pair index within the start column
	localparam int PAIR_LO = 1;
	localparam int PAIR_HI = 5;
	// command counter lanes
	localparam int EV_N = 3;
	localparam int EV_RD = 0;
	localparam int EV_WR = 1;
	localparam int EV_STOP = 2;
	// burst length codes and beat pairs per burst
	localparam logic [1:0] BURST_4 = 2'h1;
	localparam logic [1:0] BURST_8 = 2'h2;
	localparam logic [1:0] BURST_16 = 2'h3;
	localparam logic [3:0] PAIRS_4 = 4'h2;
	localparam logic [3:0] PAIRS_8 = 4'h4;
	localparam logic [3:0] PAIRS_16 = 4'h8;
	// latency pipeline and array sizes
	localparam int PIPE_DEPTH = 16;
	localparam int ADDR_W = 5;
	localparam int MEM_WORDS = 32;
	localparam int PAIR_W = 32;
	localparam int CNT_W = 8;
	localparam logic [3:0] ONE_4 = 4'h1;
	localparam logic [ADDR_W-1:0] ONE_A = 5'h01;
	localparam logic [CNT_W-1:0] ONE_C = 8'h01;

	// one beat pair slot travelling down the latency pipeline
	typedef struct packed {
		logic valid;
		logic rd;
		logic [ADDR_W-1:0] addr;
	} lbrt_slot_type;

	// static configuration from the core side
	typedef struct packed {
		logic [1:0] burst;
		logic [3:0] rd_delay;
		logic [3:0] wr_delay;
	} lbrt_cfg_type;
endpackage : lbrt_pkg

// *** bench/lbrt_ctrl_model.sv ***
// memory controller model driving the command bus and write beat pairs
`timescale 1ns/1ps
module lbrt_ctrl_model
(
	// link clock
	input wire logic link_clk_i,
	// command bus and write data
	output logic cs_n_o,
	output logic [9:0] ca_rise_o,
	output logic [9:0] ca_fall_o,
	output logic [lbrt_pkg::PAIR_W-1:0] wdata_o,
	output logic wdata_valid_o
);
	initial
	begin
		cs_n_o = 1'b1;
		ca_rise_o = 10'h2AA;
		ca_fall_o = 10'h155;
		wdata_o = 32'h0;
		wdata_valid_o = 1'b0;
	end

	// one link cycle; code zero leaves the device deselected
	task cyc(input logic [3:0] code, input logic [4:0] pair, input logic ap,
		input logic wv, input logic [31:0] wd);
		@(negedge link_clk_i);
		cs_n_o = (code == 4'h0);
		// unused lines toggle so a stale value never looks valid
		ca_rise_o = cs_n_o ? ~ca_rise_o : {3'h0, pair[0], 2'h0, code};
		ca_fall_o = cs_n_o ? ~ca_fall_o : {5'h00, pair[4:1], ap};
		wdata_valid_o = wv;
		wdata_o = wv ? wd : ~wdata_o;
	endtask : cyc
endmodule : lbrt_ctrl_model

// *** bench/tb_lpddr2_burst_rw_terminate.sv ***
// self-checking bench for the column burst block
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) \
	begin error_cnt++; $display("unexpected %s expected %h seen %h", \
	n, e, g); end end
module tb_lpddr2_burst_rw_terminate;
	localparam logic [3:0] WR = 4'h1;
	localparam logic [3:0] RD = 4'h5;
	localparam logic [3:0] ST = 4'h3;
	localparam logic [31:0] BASE = 32'hA5000000;
	localparam logic [31:0] NEWD = 32'h5E000000;
	logic core_clk, rstn, link_clk, cs_n, wdata_valid, rdq_oe, rdqs_oe;
	logic auto_close;
	logic [9:0] ca_rise, ca_fall;
	logic [31:0] wdata, rdata;
	logic [7:0] rd_count, wr_count, stop_count;
	lbrt_pkg::lbrt_cfg_type cfg;
	int error_cnt = 0;
	int comparisons = 0;
	int lc = 0;
	logic mon_en = 1'b0;
	logic [31:0] sd[$], ed[$];
	int sc[$], ec[$];

	lbrt_core uut (.core_clk_i(core_clk), .rstn_i(rstn), .cfg_i(cfg),
		.rd_count_o(rd_count), .wr_count_o(wr_count),
		.stop_count_o(stop_count), .auto_close_o(auto_close),
		.link_clk_i(link_clk), .cs_n_i(cs_n), .ca_rise_i(ca_rise),
		.ca_fall_i(ca_fall), .wdata_i(wdata), .wdata_valid_i(wdata_valid),
		.rdata_o(rdata), .rdq_oe_o(rdq_oe), .rdqs_oe_o(rdqs_oe));
	lbrt_ctrl_model u_ctrl (.link_clk_i(link_clk), .cs_n_o(cs_n),
		.ca_rise_o(ca_rise), .ca_fall_o(ca_fall), .wdata_o(wdata),
		.wdata_valid_o(wdata_valid));

	// ----------------------------------------------------------------
	// clocks and read pair monitor
	// ----------------------------------------------------------------
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial
	begin
		link_clk = 1'b0;
		#1.7;
		forever #3 link_clk = ~link_clk;
	end
	always @(posedge link_clk) lc <= lc + 1;
	always @(negedge link_clk)
	begin
		if (mon_en)
		begin
			`CHK("strobe enable", rdq_oe, rdqs_oe)
			if (rdq_oe === 1'b1)
			begin
				sd.push_back(rdata);
				sc.push_back(lc);
			end
			else `CHK("idle read data", 32'h0, rdata)
		end
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task idle(input int n);
		repeat (n) u_ctrl.cyc(4'h0, 5'h00, 1'b0, 1'b0, 32'h0);
	endtask : idle
	task want(input int c, input logic [31:0] d);
		ec.push_back(c);
		ed.push_back(d);
	endtask : want
	task judge(input string what);
		`CHK(what, ed.size(), sd.size())
		for (int i = 0; i < ed.size() && i < sd.size(); i++)
		begin
			`CHK(what, ed[i], sd[i])
			`CHK(what, ec[i], sc[i])
		end
		ed.delete();
		ec.delete();
		sd.delete();
		sc.delete();
	endtask : judge
	task counts(input logic [7:0] r, input logic [7:0] w,
		input logic [7:0] s, input logic a);
		idle(40);
		`CHK("read count", r, rd_count)
		`CHK("write count", w, wr_count)
		`CHK("stop count", s, stop_count)
		`CHK("auto close", a, auto_close)
	endtask : counts

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// two writes four clocks apart with one unbroken stream of pairs
	task t_gapless_write;
		for (int i = 0; i < 10; i++)
			u_ctrl.cyc((i == 0 || i == 4) ? WR : 4'h0, (i == 0) ? 5'h04 : 5'h08,
				1'b0, i >= 2, BASE + 32'(i - 2));
		idle(8);
	endtask : t_gapless_write
	// read cut two clocks in by a read with auto close
	task t_read_interrupt;
		int b;
		u_ctrl.cyc(RD, 5'h04, 1'b0, 1'b0, 32'h0);
		b = lc + 1;
		idle(1);
		u_ctrl.cyc(RD, 5'h08, 1'b1, 1'b0, 32'h0);
		idle(12);
		want(b + 3, BASE);
		want(b + 4, BASE + 32'h1);
		for (int k = 0; k < 4; k++)
			want(b + 5 + k, BASE + 32'(4 + k));
		judge("interrupted read");
		counts(8'h02, 8'h02, 8'h00, 1'b1);
	endtask : t_read_interrupt
	// read stopped two clocks after its command
	task t_read_stop;
		int b;
		u_ctrl.cyc(RD, 5'h06, 1'b0, 1'b0, 32'h0);
		b = lc + 1;
		idle(1);
		u_ctrl.cyc(ST, 5'h00, 1'b0, 1'b0, 32'h0);
		idle(12);
		want(b + 3, BASE + 32'h2);
		want(b + 4, BASE + 32'h3);
		judge("stopped read");
		counts(8'h03, 8'h02, 8'h01, 1'b0);
	endtask : t_read_stop
	// write stopped after two pairs; later pairs must keep old data
	task t_write_stop;
		int b;
		for (int i = 0; i < 6; i++)
			u_ctrl.cyc((i == 0) ? WR : ((i == 2) ? ST : 4'h0), 5'h08, 1'b0,
				i >= 2, NEWD + 32'(i - 2));
		idle(8);
		u_ctrl.cyc(RD, 5'h08, 1'b0, 1'b0, 32'h0);
		b = lc + 1;
		idle(12);
		want(b + 3, NEWD);
		want(b + 4, NEWD + 32'h1);
		want(b + 5, BASE + 32'h6);
		want(b + 6, BASE + 32'h7);
		judge("stopped write");
		counts(8'h04, 8'h03, 8'h02, 1'b0);
	endtask : t_write_stop
	// write cut two clocks in by a write, read back through a cut read
	task t_write_interrupt;
		int b;
		for (int i = 0; i < 8; i++)
			u_ctrl.cyc((i == 0 || i == 2) ? WR : 4'h0,
				(i == 0) ? 5'h10 : 5'h14,
				1'b0, i >= 2, BASE + 32'(i + 14));
		idle(8);
		u_ctrl.cyc(RD, 5'h10, 1'b0, 1'b0, 32'h0);
		b = lc + 1;
		idle(1);
		u_ctrl.cyc(RD, 5'h14, 1'b0, 1'b0, 32'h0);
		idle(12);
		for (int k = 0; k < 6; k++)
			want(b + 3 + k, BASE + 32'(16 + k));
		judge("interrupted write");
		counts(8'h06, 8'h05, 8'h02, 1'b0);
	endtask : t_write_interrupt
	// gapless 4-beat reads, then one 16-beat read
	task t_burst_modes;
		int b;
		@(negedge core_clk);
		cfg.burst = lbrt_pkg::BURST_4;
		idle(6);
		u_ctrl.cyc(RD, 5'h04, 1'b0, 1'b0, 32'h0);
		b = lc + 1;
		idle(1);
		u_ctrl.cyc(RD, 5'h08, 1'b0, 1'b0, 32'h0);
		idle(10);
		want(b + 3, BASE);
		want(b + 4, BASE + 32'h1);
		want(b + 5, NEWD);
		want(b + 6, NEWD + 32'h1);
		judge("short reads");
		@(negedge core_clk);
		cfg.burst = lbrt_pkg::BURST_16;
		idle(6);
		u_ctrl.cyc(RD, 5'h04, 1'b0, 1'b0, 32'h0);
		b = lc + 1;
		idle(14);
		for (int k = 0; k < 8; k++)
			want(b + 3 + k, (k == 4 || k == 5) ? NEWD + 32'(k - 4)
				: BASE + 32'(k));
		judge("long read");
		counts(8'h09, 8'h05, 8'h02, 1'b0);
	endtask : t_burst_modes

	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	task complete_run;
		if (error_cnt == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	initial
	begin
		#50000;
		error_cnt++;
		complete_run;
	end
	initial
	begin
		cfg = {lbrt_pkg::BURST_8, 4'h3, 4'h2};
		rstn = 1'b0;
		repeat (10) @(negedge core_clk);
		rstn = 1'b1;
		repeat (20) @(negedge link_clk);
		mon_en = 1'b1;
		t_gapless_write;
		t_read_interrupt;
		t_read_stop;
		t_write_stop;
		t_write_interrupt;
		t_burst_modes;
		complete_run;
	end
endmodule : tb_lpddr2_burst_rw_terminate
